// ---- hw/tdm_monitor_ci.sv ----
module tdm_monitor_ci
	import tdm_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic dcl,
	input wire logic fsc,
	input wire logic du_in,
	input wire logic dd_in,
	output logic du_out,
	output logic du_oe_n,
	output logic dd_out,
	output logic dd_oe_n
);
	logic [2:0] dcl_s, fsc_s;
	logic [1:0] du_s, dd_s;
	logic dcl_rise, dcl_fall, frame_start, fsc_last_q, rx_bit;
	logic [8:0] pos_q, pos_now, npos;
	logic [7:0] ctrl_q;
	logic [11:0] cfg_q;
	logic [3:0] mon_ch;
	logic mon_en, ack_permit, line_swap_sel, ci_length_sel, double_check_sel;
	logic wake_force_low, wake_hold_q;
	logic mon_data, mx_smp, mon_start, mon_next, mon_latch, mon_end;
	logic [7:0] mon_sh_q, monitor_rx_byte_reg;
	logic [1:0] idle_cnt_q;
	logic mon_act_q, byte_read_q, mr_q, byte_received_flag, packet_end_flag;
	logic sel, rd, wr_q, mon_rd;
	logic [7:0] waddr_q;
	logic [31:0] rdata;
	logic [5:0] ci_tx_reg [CI_CHANNELS];
	logic [5:0] ci_rx_reg [CI_CHANNELS];
	logic [5:0] ci_old_q [CI_CHANNELS];
	logic [5:0] ci_prev_q [CI_CHANNELS];
	logic [4:0] ci_sh_q [CI_CHANNELS];
	logic [CI_CHANNELS-1:0] ci_act_q, ci_free_q, change_flag, ci_rd;
	logic [CI_CHANNELS-1:0] ci_tx_hit, ci_tx_bit;
	logic tx_out, tx_oe_n;

	assign mon_en = ctrl_q[CTRL_MON_EN];
	assign ack_permit = ctrl_q[CTRL_ACK];
	assign line_swap_sel = ctrl_q[CTRL_SWAP];
	assign ci_length_sel = ctrl_q[CTRL_CI_LEN];
	assign double_check_sel = ctrl_q[CTRL_DLL];
	assign wake_force_low = ctrl_q[CTRL_WAKE];
	assign mon_ch = cfg_q[CFG_MON_LSB +: 4];

	// Link pins are asynchronous; the third stage only serves edge finding.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			dcl_s <= 3'h0;
			fsc_s <= 3'h0;
			du_s <= 2'h3;
			dd_s <= 2'h3;
		end else begin
			dcl_s <= {dcl_s[1:0], dcl};
			fsc_s <= {fsc_s[1:0], fsc};
			du_s <= {du_s[0], du_in};
			dd_s <= {dd_s[0], dd_in};
		end
	end

	assign dcl_rise = dcl_s[1] & ~dcl_s[2];
	assign dcl_fall = ~dcl_s[1] & dcl_s[2];
	assign rx_bit = line_swap_sel ? du_s[1] : dd_s[1];
	assign frame_start = dcl_rise & fsc_s[1] & ~fsc_last_q;
	assign pos_now = frame_start ? 9'h000 : pos_q + 9'h001;
	assign npos = pos_q + 9'h001;

	// Bit position in the frame: multiplex, byte and bit, MSB first.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pos_q <= 9'h000;
			fsc_last_q <= 1'b0;
		end else if (dcl_rise) begin
			pos_q <= pos_now;
			fsc_last_q <= fsc_s[1];
		end
	end

	// Monitor slot data and MX sampling points.
	assign mon_data = dcl_rise && pos_now[8:5] == mon_ch
		&& pos_now[4:3] == BYTE_MON;
	assign mx_smp = dcl_rise && pos_now[8:5] == mon_ch
		&& pos_now[4:3] == BYTE_CTL && pos_now[2:0] == BIT_MX;
	assign mon_start = mon_en && mx_smp && !rx_bit
		&& idle_cnt_q == IDLE_FRAMES;
	assign mon_next = mon_en && mx_smp && !rx_bit && idle_cnt_q == 2'h1
		&& mon_act_q && ack_permit && byte_read_q;
	assign mon_latch = mon_start || mon_next;
	assign mon_end = mon_en && mx_smp && rx_bit && idle_cnt_q == 2'h1
		&& mon_act_q;

	// The data byte is shifted in before MX arrives in the next byte.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			mon_sh_q <= 8'h00;
		end else if (mon_data) begin
			mon_sh_q <= {mon_sh_q[6:0], rx_bit};
		end
	end

	// Consecutive idle MX frames, saturating; disabled receiver forgets.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			idle_cnt_q <= 2'h0;
		end else if (!mon_en) begin
			idle_cnt_q <= 2'h0;
		end else if (mx_smp) begin
			if (!rx_bit) begin
				idle_cnt_q <= 2'h0;
			end else if (idle_cnt_q != IDLE_FRAMES) begin
				idle_cnt_q <= idle_cnt_q + 2'h1;
			end
		end
	end

	// Packet state and the latched byte. Bytes are taken as seen once,
	// without comparing against the previous frame.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			mon_act_q <= 1'b0;
			monitor_rx_byte_reg <= 8'h00;
		end else begin
			if (!mon_en) begin
				mon_act_q <= 1'b0;
			end else if (mon_start) begin
				mon_act_q <= 1'b1;
			end else if (mon_end) begin
				mon_act_q <= 1'b0;
			end
			if (mon_latch) begin
				monitor_rx_byte_reg <= mon_sh_q;
			end
		end
	end

	// A fresh byte is unread; the software read marks it read.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			byte_read_q <= 1'b0;
		end else if (mon_latch) begin
			byte_read_q <= 1'b0;
		end else if (mon_rd) begin
			byte_read_q <= 1'b1;
		end
	end

	// MR changes once a frame, so an ack shows in the frame after a read.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			mr_q <= 1'b1;
		end else if (!mon_en) begin
			mr_q <= 1'b1;
		end else if (mx_smp) begin
			mr_q <= !(mon_act_q && !mon_end && !mon_latch && ack_permit
				&& byte_read_q);
		end
	end

	// Sticky monitor flags; a set in the clearing cycle wins.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			byte_received_flag <= 1'b0;
			packet_end_flag <= 1'b0;
		end else begin
			if (mon_latch) begin
				byte_received_flag <= 1'b1;
			end else if (mon_rd) begin
				byte_received_flag <= 1'b0;
			end
			if (mon_end) begin
				packet_end_flag <= 1'b1;
			end else if (wr_q && waddr_q == ADDR_STATUS
				&& hwdata[ST_END]) begin
				packet_end_flag <= 1'b0;
			end
		end
	end

	// One handler per C/I channel.
	for (genvar i = 0; i < CI_CHANNELS; i++) begin : g_ci
		logic [3:0] ch;
		logic [2:0] lo;
		logic in_field, ci_smp, tx_field;
		logic [5:0] code;
		assign ch = cfg_q[CFG_CI_LSB + 4*i +: 4];
		assign lo = ci_length_sel ? 3'h0 : BIT_CI4_FIRST;
		assign in_field = dcl_rise && pos_now[8:5] == ch
			&& pos_now[4:3] == BYTE_CTL && pos_now[2:0] >= lo
			&& pos_now[2:0] <= BIT_CI_LAST;
		assign ci_smp = in_field && pos_now[2:0] == BIT_CI_LAST;
		assign code = ci_length_sel ? {ci_sh_q[i], rx_bit}
			: {2'h0, ci_sh_q[i][2:0], rx_bit};
		assign tx_field = npos[8:5] == ch && npos[4:3] == BYTE_CTL
			&& npos[2:0] >= lo && npos[2:0] <= BIT_CI_LAST;
		assign ci_tx_hit[i] = ci_act_q[i] && tx_field;
		assign ci_tx_bit[i] = ci_tx_reg[i][BIT_CI_LAST - npos[2:0]];

		// Enable takes hold only at a frame start, so no partial code
		// is sent or received.
		always_ff @(posedge clk or posedge reset) begin
			if (reset) begin
				ci_act_q[i] <= 1'b0;
			end else if (!ctrl_q[CTRL_CI_EN0 + i]) begin
				ci_act_q[i] <= 1'b0;
			end else if (frame_start) begin
				ci_act_q[i] <= 1'b1;
			end
		end

		// Receive shift, previous and old-confirmed codes.
		always_ff @(posedge clk or posedge reset) begin
			if (reset) begin
				ci_sh_q[i] <= 5'h00;
				ci_prev_q[i] <= 6'h00;
				ci_old_q[i] <= 6'h00;
			end else begin
				if (in_field) begin
					ci_sh_q[i] <= {ci_sh_q[i][3:0], rx_bit};
				end
				if (ci_smp && ci_act_q[i]) begin
					ci_prev_q[i] <= code;
					if ((!double_check_sel || code == ci_prev_q[i])
						&& code != ci_old_q[i]) begin
						ci_old_q[i] <= code;
					end
				end
			end
		end

		// The receive register loads only once the last value was read,
		// so intermediate codes are lost by design.
		always_ff @(posedge clk or posedge reset) begin
			if (reset) begin
				ci_rx_reg[i] <= 6'h00;
				ci_free_q[i] <= 1'b1;
				change_flag[i] <= 1'b0;
			end else if (ci_free_q[i] && ci_old_q[i] != ci_rx_reg[i]) begin
				ci_rx_reg[i] <= ci_old_q[i];
				ci_free_q[i] <= 1'b0;
				change_flag[i] <= 1'b1;
			end else if (ci_rd[i]) begin
				ci_free_q[i] <= 1'b1;
				change_flag[i] <= 1'b0;
			end
		end
	end

	// Wake hold ends only at a detected frame sync after release.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			wake_hold_q <= 1'b0;
		end else if (wake_force_low) begin
			wake_hold_q <= 1'b1;
		end else if (frame_start) begin
			wake_hold_q <= 1'b0;
		end
	end

	// Transmit line content for the coming bit; wake beats everything.
	always_comb begin
		tx_out = 1'b1;
		tx_oe_n = 1'b1;
		if (wake_hold_q) begin
			tx_out = 1'b0;
			tx_oe_n = 1'b0;
		end else if (mon_en && npos[8:5] == mon_ch
			&& npos[4:3] == BYTE_CTL && npos[2:0] == BIT_MR) begin
			tx_out = mr_q;
			tx_oe_n = 1'b0;
		end else if (ci_tx_hit[0]) begin
			tx_out = ci_tx_bit[0];
			tx_oe_n = 1'b0;
		end else if (ci_tx_hit[1]) begin
			tx_out = ci_tx_bit[1];
			tx_oe_n = 1'b0;
		end
	end

	// Output pins change on the falling bit clock, or at once while waking,
	// because the clock may be stopped then.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			du_out <= 1'b1;
			du_oe_n <= 1'b1;
			dd_out <= 1'b1;
			dd_oe_n <= 1'b1;
		end else if (dcl_fall || wake_hold_q) begin
			du_out <= line_swap_sel ? 1'b1 : tx_out;
			du_oe_n <= line_swap_sel ? 1'b1 : tx_oe_n;
			dd_out <= line_swap_sel ? tx_out : 1'b1;
			dd_oe_n <= line_swap_sel ? tx_oe_n : 1'b1;
		end
	end

	// AHB-Lite slave with no wait states; reads have side effects.
	assign sel = hsel && htrans[1] && hready && hsize == 3'h2;
	assign rd = sel && !hwrite;
	assign mon_rd = rd && haddr[7:0] == ADDR_MON_RX;
	assign ci_rd[0] = rd && haddr[7:0] == ADDR_CI_RX0;
	assign ci_rd[1] = rd && haddr[7:0] == ADDR_CI_RX1;

	// Read data mux; unmapped addresses read zero.
	always_comb begin
		rdata = 32'h0000_0000;
		if (haddr[7:0] == ADDR_CTRL) begin
			rdata[7:0] = ctrl_q;
		end else if (haddr[7:0] == ADDR_CFG) begin
			rdata[11:0] = cfg_q;
		end else if (haddr[7:0] == ADDR_STATUS) begin
			rdata[ST_BYTE] = byte_received_flag;
			rdata[ST_END] = packet_end_flag;
			rdata[ST_CHG0 +: 2] = change_flag;
			rdata[ST_ACTIVE] = mon_act_q;
		end else if (haddr[7:0] == ADDR_MON_RX) begin
			rdata[7:0] = monitor_rx_byte_reg;
		end else if (haddr[7:0] == ADDR_CI_RX0) begin
			rdata[5:0] = ci_rx_reg[0];
		end else if (haddr[7:0] == ADDR_CI_RX1) begin
			rdata[5:0] = ci_rx_reg[1];
		end else if (haddr[7:0] == ADDR_CI_TX0) begin
			rdata[5:0] = ci_tx_reg[0];
		end else if (haddr[7:0] == ADDR_CI_TX1) begin
			rdata[5:0] = ci_tx_reg[1];
		end
	end

	// Address phase capture and read data.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			wr_q <= 1'b0;
			waddr_q <= 8'h00;
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			wr_q <= sel && hwrite;
			waddr_q <= haddr[7:0];
			if (rd) begin
				hrdata <= rdata;
			end
		end
	end

	// Writes land in the data phase.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ctrl_q <= CTRL_RST;
			cfg_q <= CFG_RST;
			ci_tx_reg[0] <= 6'h3F;
			ci_tx_reg[1] <= 6'h3F;
		end else if (wr_q) begin
			if (waddr_q == ADDR_CTRL) begin
				ctrl_q <= hwdata[7:0];
			end else if (waddr_q == ADDR_CFG) begin
				cfg_q <= hwdata[11:0];
			end else if (waddr_q == ADDR_CI_TX0) begin
				ci_tx_reg[0] <= hwdata[5:0];
			end else if (waddr_q == ADDR_CI_TX1) begin
				ci_tx_reg[1] <= hwdata[5:0];
			end
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	sequence s_wake_off;
		!wake_force_low && wake_hold_q && !frame_start;
	endsequence
	sequence s_ci_blocked;
		!ci_free_q[0] && !ci_rd[0];
	endsequence

	a_rx_disabled: assert property (!mon_en |-> !mon_latch && !mon_end)
		else $error("monitor acted while disabled");
	a_first_latch: assert property (mon_start |=> mon_act_q
		&& monitor_rx_byte_reg == $past(mon_sh_q))
		else $error("first byte not latched");
	a_mr_ack: assert property (mx_smp && mon_en && mon_act_q
		&& ack_permit && byte_read_q && !mon_latch && !mon_end |=> !mr_q)
		else $error("read byte not acknowledged");
	a_byte_flag: assert property (mon_latch |=> byte_received_flag)
		else $error("byte flag not set");
	a_end_idle: assert property (mon_end |=> packet_end_flag && mr_q
		&& !mon_act_q)
		else $error("packet end not handled");
	a_later_gate: assert property (mon_latch && mon_act_q
		|-> ack_permit && byte_read_q && idle_cnt_q == 2'h1)
		else $error("later byte latched without permission");
	// The pins were loaded with the swap setting of the previous cycle.
	a_wake_low: assert property (wake_hold_q |=> ($past(line_swap_sel)
		? (!dd_out && !dd_oe_n) : (!du_out && !du_oe_n)))
		else $error("wake did not drive line low");
	a_wake_release: assert property (s_wake_off |=> wake_hold_q)
		else $error("wake released before frame sync");
	a_ci_hiz: assert property (dcl_fall && !wake_hold_q && !mon_en
		&& ci_act_q == 2'h0 |=> du_oe_n && dd_oe_n)
		else $error("idle line driven");
	a_ci_hold: assert property (s_ci_blocked |=> $stable(ci_rx_reg[0]))
		else $error("unread code overwritten");
	a_ci_load: assert property (ci_free_q[0]
		&& ci_old_q[0] != ci_rx_reg[0] |=> change_flag[0]
		&& ci_rx_reg[0] == $past(ci_old_q[0]) ##1 $stable(ci_rx_reg[0]))
		else $error("confirmed code not loaded");
endmodule : tdm_monitor_ci

// ---- hw/tdm_pkg.sv ----
package tdm_pkg;
	// Register byte addresses.
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_CFG = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_MON_RX = 8'h0C;
	localparam logic [7:0] ADDR_CI_RX0 = 8'h10;
	localparam logic [7:0] ADDR_CI_RX1 = 8'h14;
	localparam logic [7:0] ADDR_CI_TX0 = 8'h18;
	localparam logic [7:0] ADDR_CI_TX1 = 8'h1C;
	// Control register fields.
	localparam int CTRL_MON_EN = 0;
	localparam int CTRL_ACK = 1;
	localparam int CTRL_SWAP = 2;
	localparam int CTRL_CI_LEN = 3;
	localparam int CTRL_DLL = 4;
	localparam int CTRL_WAKE = 5;
	localparam int CTRL_CI_EN0 = 6;
	localparam logic [7:0] CTRL_RST = 8'h00;
	// Configuration fields: monitor slot, then one slot per C/I channel.
	localparam int CFG_MON_LSB = 0;
	localparam int CFG_CI_LSB = 4;
	localparam logic [11:0] CFG_RST = 12'h000;
	// Status fields.
	localparam int ST_BYTE = 0;
	localparam int ST_END = 1;
	localparam int ST_CHG0 = 2;
	localparam int ST_ACTIVE = 4;
	// Frame layout and handshake constants.
	localparam logic [1:0] BYTE_MON = 2'h2;
	localparam logic [1:0] BYTE_CTL = 2'h3;
	localparam logic [2:0] BIT_MR = 3'h6;
	localparam logic [2:0] BIT_MX = 3'h7;
	localparam logic [2:0] BIT_CI_LAST = 3'h5;
	localparam logic [2:0] BIT_CI4_FIRST = 3'h2;
	localparam logic [1:0] IDLE_FRAMES = 2'h2;
	localparam int CI_CHANNELS = 2;
endpackage : tdm_pkg

// ---- verification/tdm_far_end.sv ----
module tdm_far_end (
	input wire logic run,
	input wire logic [7:0] mon,
	input wire logic mx,
	input wire logic [5:0] ci,
	input wire logic tx,
	input wire logic tx_oe_n,
	output logic dcl,
	output logic fsc,
	output logic line,
	output logic mr_seen,
	output logic [5:0] ci_seen,
	output int frames,
	output int drv
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] fr;
	int p;
	// One bit per link clock period, MSB first; the clock stops only at a
	// frame edge, and released bit times toggle so nothing stale is seen.
	initial begin
		{dcl, fsc, line, mr_seen, ci_seen} = '0;
		fr = '1;
		{frames, drv, p} = '0;
		forever begin
			if (!run && p == 0) begin
				line = ~line;
				#125;
			end else begin
				if (p == 0)
					fr = {16'h0000, mon, ci, 1'b1, mx};
				fsc = (p == 0);
				line = (p < 16 || p == 30) ? ~line : fr[31 - p];
				#62.5;
				dcl = 1'b1;
				if (p == 30)
					mr_seen = tx;
				if (p >= 24 && p <= 29)
					ci_seen[29 - p] = tx;
				if (!tx_oe_n)
					drv++;
				#62.5;
				dcl = 1'b0;
				p = (p + 1) % 32;
				if (p == 0)
					frames++;
			end
		end
	end
endmodule : tdm_far_end

// ---- verification/tb_tdm_monitor_ci.sv ----
`define CHK(g, x) begin \
	n_compared++; \
	if ((g) !== (x)) begin \
		n_fail++; \
		$display("[ERR] %0t got %h exp %h", $time, g, x); \
	end \
end
module tb_tdm_monitor_ci
	import tdm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, reset, hsel, hwrite, run, mx, tgl, dp_rd;
	logic [31:0] haddr, hwdata, hrdata, e;
	logic [1:0] htrans;
	logic [7:0] mon;
	logic [5:0] ci, ci_seen;
	logic hreadyout, hresp, dcl, fsc, du_out, du_oe_n, dd_out, dd_oe_n;
	logic far_line, mr_seen;
	int frames, drv, n_fail, n_compared, cycles;
	logic [31:0] q[$];
	// Each line level is the driving party's value; a free line toggles.
	wire du_w = !du_oe_n ? du_out : tgl;
	wire dd_w = !dd_oe_n ? dd_out : far_line;

	tdm_monitor_ci DUT (.clk(clk), .reset(reset), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .dcl(dcl), .fsc(fsc),
		.du_in(du_w), .dd_in(dd_w), .du_out(du_out), .du_oe_n(du_oe_n),
		.dd_out(dd_out), .dd_oe_n(dd_oe_n));
	tdm_far_end far (.run(run), .mon(mon), .mx(mx), .ci(ci), .tx(du_w),
		.tx_oe_n(du_oe_n), .dcl(dcl), .fsc(fsc), .line(far_line),
		.mr_seen(mr_seen), .ci_seen(ci_seen), .frames(frames), .drv(drv));

	// System clock.
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic summarize();
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : summarize

	// Cycle ceiling, plus the toggle pattern of a released line.
	always @(posedge clk) begin
		tgl <= ~tgl;
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			n_fail++;
			summarize();
		end
	end

	// Read data is taken at the edge closing the data phase, oldest note first.
	always @(posedge clk) begin
		if (dp_rd) begin
			e = q.pop_front();
			`CHK(hrdata, e)
		end
		dp_rd <= hsel && htrans[1] && !hwrite && hreadyout;
	end

	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h00_0000, a};
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
	endtask : bus

	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		q.push_back(x);
		bus(1'b0, a, 32'h0);
	endtask : rd

	// Values given here stand for exactly n frames on the link.
	task automatic sendf(input logic [7:0] m, input logic x,
		input logic [5:0] c, input int n);
		@(posedge clk);
		mon <= m;
		mx <= x;
		ci <= c;
		repeat (n) @(frames);
	endtask : sendf

	task automatic ci_f(input logic [5:0] c, input int n);
		sendf(8'hFF, 1'b1, c, n);
	endtask : ci_f

	// Main sequence: wake hold, monitor packets, then C/I changes.
	initial begin
		logic [7:0] b0, b1, b2;
		logic [3:0] c1;
		logic [5:0] d1;
		int d0;
		reset = 1'b1;
		{hsel, hwrite, run, tgl, dp_rd} = '0;
		{haddr, hwdata, htrans, ci} = '0;
		mon = 8'hFF;
		mx = 1'b1;
		{n_fail, n_compared, cycles} = '0;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		void'($urandom(32'h67c7_ac46));
		rd(ADDR_CTRL, 32'h0);
		rd(ADDR_STATUS, 32'h0);
		rd(ADDR_CI_TX0, 32'h3F);
		rd(8'h40, 32'h0);
		`CHK(hresp, 1'b0)
		// The link clock is stopped while wake is requested.
		bus(1'b1, ADDR_CTRL, 32'h20);
		repeat (3) @(posedge clk);
		`CHK({du_out, du_oe_n, dd_oe_n}, 3'h1)
		bus(1'b1, ADDR_CTRL, 32'h24);
		repeat (3) @(posedge clk);
		`CHK({dd_out, dd_oe_n, du_oe_n}, 3'h1)
		bus(1'b1, ADDR_CTRL, 32'h20);
		bus(1'b1, ADDR_CTRL, 32'h0);
		repeat (20) @(posedge clk);
		`CHK({du_out, du_oe_n}, 2'h0)
		run <= 1'b1;
		repeat (2) @(frames);
		d0 = drv;
		sendf(8'h5A, 1'b0, 6'h0, 3);
		sendf(8'hFF, 1'b1, 6'h0, 3);
		`CHK(drv - d0, 0)
		rd(ADDR_STATUS, 32'h0);
		bus(1'b1, ADDR_CTRL, 32'h3);
		sendf(8'hFF, 1'b1, 6'h0, 2);
		b0 = 8'($urandom);
		sendf(b0, 1'b0, 6'h0, 3);
		rd(ADDR_STATUS, 32'h11);
		rd(ADDR_MON_RX, {24'h0, b0});
		sendf(b0, 1'b0, 6'h0, 2);
		`CHK(mr_seen, 1'b0)
		b1 = 8'($urandom);
		sendf(~b1, 1'b1, 6'h0, 1);
		sendf(b1, 1'b0, 6'h0, 3);
		`CHK(mr_seen, 1'b1)
		rd(ADDR_STATUS, 32'h11);
		rd(ADDR_MON_RX, {24'h0, b1});
		sendf(b1, 1'b0, 6'h0, 2);
		`CHK(mr_seen, 1'b0)
		sendf(8'hFF, 1'b1, 6'h0, 4);
		`CHK(mr_seen, 1'b1)
		rd(ADDR_STATUS, 32'h2);
		bus(1'b1, ADDR_STATUS, 32'h2);
		rd(ADDR_STATUS, 32'h0);
		// Without ack permit a second byte must not be latched.
		bus(1'b1, ADDR_CTRL, 32'h1);
		b2 = 8'($urandom);
		sendf(b2, 1'b0, 6'h0, 3);
		rd(ADDR_MON_RX, {24'h0, b2});
		sendf(b2 ^ 8'h3C, 1'b1, 6'h0, 1);
		sendf(b2 ^ 8'h3C, 1'b0, 6'h0, 3);
		rd(ADDR_STATUS, 32'h10);
		rd(ADDR_MON_RX, {24'h0, b2});
		sendf(8'hFF, 1'b1, 6'h0, 4);
		bus(1'b1, ADDR_STATUS, 32'h2);
		// Single look: the first change loads, the newest one loads after a read.
		bus(1'b1, ADDR_CI_TX0, 32'h6);
		bus(1'b1, ADDR_CTRL, 32'h40);
		c1 = 4'($urandom_range(15, 1));
		ci_f({2'h0, c1}, 3);
		`CHK(ci_seen[3:0], 4'h6)
		rd(ADDR_STATUS, 32'h4);
		rd(ADDR_CI_RX0, {28'h0, c1});
		ci_f({2'h0, c1 ^ 4'h5}, 2);
		ci_f({2'h0, c1 ^ 4'hA}, 2);
		ci_f({2'h0, c1 ^ 4'hF}, 2);
		rd(ADDR_CI_RX0, {28'h0, c1 ^ 4'h5});
		ci_f({2'h0, c1 ^ 4'hF}, 2);
		rd(ADDR_STATUS, 32'h4);
		rd(ADDR_CI_RX0, {28'h0, c1 ^ 4'hF});
		bus(1'b1, ADDR_CTRL, 32'h60);
		ci_f({2'h0, c1 ^ 4'hF}, 2);
		`CHK(ci_seen[3:0], 4'h0)
		// Double look with six bit codes: a one-frame glitch is never loaded.
		bus(1'b1, ADDR_CTRL, 32'h58);
		d1 = 6'($urandom) & 6'h1F;
		ci_f(d1, 1);
		ci_f(d1 ^ 6'h2A, 3);
		rd(ADDR_STATUS, 32'h4);
		rd(ADDR_CI_RX0, {26'h0, d1 ^ 6'h2A});
		`CHK(ci_seen, 6'h06)
		summarize();
	end
endmodule : tb_tdm_monitor_ci
